// ### include/isa_cmd_map.svh
// Purpose: Constants for the ISA command, strobe and byte-enable block
// Assumes: Cycle lengths counted in ISA bus clocks, address phase included
// Notes: Timing figures are whole bus clocks
// How it works
// - As master, drive byte-high enable whenever the upper data lane carries a byte.
// - Byte-high enable stays negated throughout every refresh cycle.
// - Pull 16-bit memory select low for ISA master cycles into PCI memory.
// - Once an external master holds the bus, never reclaim it until released.
// - Drive memory strobes while owning the bus; treat as inputs otherwise.
// - Memory read strobe is also driven during refresh cycles.
// - Compatible DMA asserts memory strobes only for addresses below 16 Mbytes.
// - Fast DMA types A, B and F never drive memory strobes active.
// - System memory strobes only assert for accesses below the first megabyte.
// - System memory strobes are delayed copies of the memory strobes.
// - System memory strobes are driven high during reset.
// - Zero-wait request shortens 16-bit memory to 2 clocks, 8-bit to 3.
// - Zero-wait request is ignored on 16-bit I/O cycles.
// - A wait request in the same clock overrides the zero-wait request.
// - Bus reset is asserted for as long as the PCI-side reset is.
// - Bus reset can also be asserted by a software control bit.
// - Data bus is tristated during reset; undefined during refresh.
`ifndef ISA_CMD_MAP_SVH
`define ISA_CMD_MAP_SVH

`define ISA_LEN_NORM16 3'h3
`define ISA_LEN_NORM8 3'h6
`define ISA_LEN_ZWS16 3'h2
`define ISA_LEN_ZWS8 3'h3
`define ISA_LIM16M_MSB 31
`define ISA_LIM16M_LSB 24
`define ISA_LIM1M_LSB 20
`define ISA_STROBE_RST 1'h1
`define ISA_RSTDRV_RST 1'h1

`endif

// ### include/isa_cmd_pkg.sv
// Purpose: Types for the ISA command block
// Assumes: Nothing beyond the constants header
// Notes: Cycle kind is chosen by the PCI-side requester
package isa_cmd_pkg;
    typedef enum logic [1:0] {
        KIND_MASTER,
        KIND_COMPAT_DMA,
        KIND_FAST_DMA,
        KIND_REFRESH
    } kind_e;
    typedef enum logic [1:0] {
        ST_IDLE,
        ST_ADDR,
        ST_CMD,
        ST_END
    } bus_state_e;
endpackage

// ### src/isa_bus_command_interface.sv
// Purpose: ISA-side command strobes, byte enable, zero-wait and bus reset drive
// Assumes: i_bus_clk is the ISA bus clock; requests come from the 20 MHz core side
// Notes: Requests cross by a toggle handshake; held words stay stable meanwhile
`timescale 1ns/10ps
`include "isa_cmd_map.svh"
module isa_bus_command_interface (
    // Core clock and reset
    input wire logic i_clk,
    input wire logic i_reset_n,
    // ISA bus clock
    input wire logic i_bus_clk,
    // Request from PCI side
    input wire logic i_req_valid,
    input wire isa_cmd_pkg::kind_e i_req_kind,
    input wire logic i_req_write,
    input wire logic i_req_mem,
    input wire logic i_req_16bit,
    input wire logic [31:0] i_req_addr,
    input wire logic [1:0] i_req_be,
    input wire logic [15:0] i_req_wdata,
    output logic o_req_busy,
    output logic o_done,
    output logic [15:0] o_rdata,
    // Control and PCI memory window on LA
    input wire logic i_soft_bus_reset,
    input wire logic [6:0] i_pci_la_lo,
    input wire logic [6:0] i_pci_la_hi,
    // ISA inputs
    input wire logic i_master_n,
    input wire logic i_memr_n,
    input wire logic i_memw_n,
    input wire logic [6:0] i_la,
    input wire logic i_iochrdy,
    input wire logic i_zerows_n,
    input wire logic [15:0] i_sd,
    // ISA command outputs
    output logic o_memr_n,
    output logic o_memw_n,
    output logic o_ior_n,
    output logic o_iow_n,
    output logic o_cmd_oe,
    output logic o_smemr_n,
    output logic o_smemw_n,
    output logic o_sbhe_n,
    output logic o_sbhe_oe,
    output logic o_memcs16_n,
    output logic o_memcs16_oe,
    output logic o_rstdrv,
    output logic [15:0] o_sd,
    output logic o_sd_oe
);

    // ----------------------------------------
    // Core-side state
    // ----------------------------------------
    typedef struct packed {
        logic busy;
        logic req_tgl;
        logic done_s1;
        logic done_s2;
        logic done_seen;
        logic done;
        logic [15:0] rdata;
        isa_cmd_pkg::kind_e kind;
        logic write;
        logic mem;
        logic w16;
        logic [31:0] addr;
        logic [1:0] be;
        logic [15:0] wdata;
    } core_s;

    // ----------------------------------------
    // Bus-side state
    // ----------------------------------------
    typedef struct packed {
        logic req_s1;
        logic req_s2;
        logic req_seen;
        logic done_tgl;
        logic rst_s1;
        logic rst_s2;
        logic mst_s1;
        logic mst_s2;
        logic mr_s1;
        logic mr_s2;
        logic mw_s1;
        logic mw_s2;
        logic [6:0] la_s1;
        logic [6:0] la_s2;
        logic [6:0] lo_s1;
        logic [6:0] lo_s2;
        logic [6:0] hi_s1;
        logic [6:0] hi_s2;
        isa_cmd_pkg::bus_state_e st;
        logic [2:0] cnt;
        logic [2:0] len;
        logic [2:0] len_zws;
        logic zws_ok;
        logic below1m;
        logic [15:0] rdata;
        logic memr_n;
        logic memw_n;
        logic ior_n;
        logic iow_n;
        logic cmd_oe;
        logic smemr_n;
        logic smemw_n;
        logic sbhe_n;
        logic sbhe_oe;
        logic memcs_oe;
        logic rstdrv;
        logic [15:0] sd;
        logic sd_oe;
    } bus_s;

    core_s cq;
    core_s cd;
    bus_s bq;
    bus_s bd;

    // ----------------------------------------
    // Core side: take request, wait for completion
    // ----------------------------------------
    always_comb begin
        cd = cq;
        cd.done = 1'h0;
        cd.done_s1 = bq.done_tgl;
        cd.done_s2 = cq.done_s1;
        if (!cq.busy && i_req_valid) begin
            cd.busy = 1'h1;
            cd.req_tgl = ~cq.req_tgl;
            cd.kind = i_req_kind;
            cd.write = i_req_write;
            cd.mem = i_req_mem;
            cd.w16 = i_req_16bit;
            cd.addr = i_req_addr;
            cd.be = i_req_be;
            cd.wdata = i_req_wdata;
        end
        // Bus read data is held still from the toggle until the next request
        if (cq.busy && (cq.done_s2 != cq.done_seen)) begin
            cd.done_seen = cq.done_s2;
            cd.busy = 1'h0;
            cd.done = 1'h1;
            cd.rdata = bq.rdata;
        end
    end

    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            cq <= '0;
        end else begin
            cq <= cd;
        end
    end

    assign o_req_busy = cq.busy;
    assign o_done = cq.done;
    assign o_rdata = cq.rdata;

    // ----------------------------------------
    // Bus side: cycle sequencer and strobes
    // ----------------------------------------
    logic ext_own;
    logic wait_req;
    logic zws_req;
    logic short_ok;
    logic [2:0] cnt_n;
    logic [2:0] end_len;
    logic la_hit;
    logic ext_below1m;

    always_comb begin
        bd = bq;
        bd.req_s1 = cq.req_tgl;
        bd.req_s2 = bq.req_s1;
        bd.rst_s1 = i_soft_bus_reset;
        bd.rst_s2 = bq.rst_s1;
        bd.mst_s1 = i_master_n;
        bd.mst_s2 = bq.mst_s1;
        bd.mr_s1 = i_memr_n;
        bd.mr_s2 = bq.mr_s1;
        bd.mw_s1 = i_memw_n;
        bd.mw_s2 = bq.mw_s1;
        bd.la_s1 = i_la;
        bd.la_s2 = bq.la_s1;
        bd.lo_s1 = i_pci_la_lo;
        bd.lo_s2 = bq.lo_s1;
        bd.hi_s1 = i_pci_la_hi;
        bd.hi_s2 = bq.hi_s1;
        ext_own = !bq.mst_s2;
        // Slave answers are launched on this bus clock; a sync stage would eat the zero-wait gain
        // Ready low means the slave is asking for wait states
        wait_req = !i_iochrdy;
        zws_req = !i_zerows_n;
        short_ok = zws_req && !wait_req && bq.zws_ok;
        cnt_n = bq.cnt + 3'h1;
        end_len = short_ok ? bq.len_zws : bq.len;
        la_hit = (bq.la_s2 >= bq.lo_s2) && (bq.la_s2 <= bq.hi_s2);
        ext_below1m = (bq.la_s2[6:3] == 4'h0);
        bd.rstdrv = bq.rst_s2;
        case (bq.st)
            isa_cmd_pkg::ST_IDLE: begin
                bd.cmd_oe = !ext_own;
                bd.sbhe_oe = 1'h0;
                bd.sd_oe = 1'h0;
                // No new cycle starts while an external master holds the bus
                if ((bq.req_s2 != bq.req_seen) && !ext_own) begin
                    bd.req_seen = bq.req_s2;
                    bd.st = isa_cmd_pkg::ST_ADDR;
                    bd.cmd_oe = 1'h1;
                    bd.sbhe_oe = 1'h1;
                    bd.sbhe_n = !cq.be[1] || (cq.kind == isa_cmd_pkg::KIND_REFRESH);
                    bd.sd = cq.wdata;
                    bd.sd_oe = cq.write && (cq.kind != isa_cmd_pkg::KIND_REFRESH);
                    bd.below1m = (cq.addr[`ISA_LIM16M_MSB:`ISA_LIM1M_LSB] == 12'h000);
                    if (cq.w16) begin
                        bd.len = `ISA_LEN_NORM16;
                        bd.len_zws = `ISA_LEN_ZWS16;
                    end else begin
                        bd.len = `ISA_LEN_NORM8;
                        bd.len_zws = `ISA_LEN_ZWS8;
                    end
                    bd.zws_ok = cq.mem || !cq.w16;
                end
            end
            isa_cmd_pkg::ST_ADDR: begin
                bd.st = isa_cmd_pkg::ST_CMD;
                bd.cnt = 3'h1;
                if (cq.kind == isa_cmd_pkg::KIND_REFRESH) begin
                    bd.memr_n = 1'h0;
                end else if (cq.mem) begin
                    // Fast DMA and compatible DMA above 16 Mbytes run with no strobe
                    if ((cq.kind != isa_cmd_pkg::KIND_FAST_DMA) &&
                        ((cq.kind != isa_cmd_pkg::KIND_COMPAT_DMA) ||
                         (cq.addr[`ISA_LIM16M_MSB:`ISA_LIM16M_LSB] == 8'h00))) begin
                        bd.memr_n = cq.write;
                        bd.memw_n = !cq.write;
                    end
                end else begin
                    bd.ior_n = cq.write;
                    bd.iow_n = !cq.write;
                end
            end
            isa_cmd_pkg::ST_CMD: begin
                if (!wait_req) begin
                    bd.cnt = cnt_n;
                end
                if (!wait_req && (cnt_n >= end_len)) begin
                    bd.memr_n = 1'h1;
                    bd.memw_n = 1'h1;
                    bd.ior_n = 1'h1;
                    bd.iow_n = 1'h1;
                    bd.rdata = i_sd;
                    bd.st = isa_cmd_pkg::ST_END;
                end
            end
            isa_cmd_pkg::ST_END: begin
                bd.sd_oe = 1'h0;
                bd.sbhe_oe = 1'h0;
                bd.sbhe_n = 1'h1;
                bd.done_tgl = ~bq.done_tgl;
                bd.st = isa_cmd_pkg::ST_IDLE;
            end
            default: begin
                bd.st = isa_cmd_pkg::ST_IDLE;
            end
        endcase
        // One bus clock behind our own memory strobes, after two sync stages for an external master's, gated to the first megabyte
        if (ext_own) begin
            bd.smemr_n = !(!bq.mr_s2 && ext_below1m);
            bd.smemw_n = !(!bq.mw_s2 && ext_below1m);
        end else begin
            bd.smemr_n = !(!bq.memr_n && bq.below1m);
            bd.smemw_n = !(!bq.memw_n && bq.below1m);
        end
        // Decode of the upper address only; the command lines play no part
        bd.memcs_oe = ext_own && la_hit;
    end

    always_ff @(posedge i_bus_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            bq <= '0;
            bq.st <= isa_cmd_pkg::ST_IDLE;
            bq.mst_s1 <= 1'h1;
            bq.mst_s2 <= 1'h1;
            bq.mr_s1 <= 1'h1;
            bq.mr_s2 <= 1'h1;
            bq.mw_s1 <= 1'h1;
            bq.mw_s2 <= 1'h1;
            bq.memr_n <= `ISA_STROBE_RST;
            bq.memw_n <= `ISA_STROBE_RST;
            bq.ior_n <= `ISA_STROBE_RST;
            bq.iow_n <= `ISA_STROBE_RST;
            bq.smemr_n <= `ISA_STROBE_RST;
            bq.smemw_n <= `ISA_STROBE_RST;
            bq.sbhe_n <= 1'h1;
            bq.rstdrv <= `ISA_RSTDRV_RST;
            bq.sd_oe <= 1'h0;
        end else begin
            bq <= bd;
        end
    end

    assign o_memr_n = bq.memr_n;
    assign o_memw_n = bq.memw_n;
    assign o_ior_n = bq.ior_n;
    assign o_iow_n = bq.iow_n;
    assign o_cmd_oe = bq.cmd_oe;
    assign o_smemr_n = bq.smemr_n;
    assign o_smemw_n = bq.smemw_n;
    assign o_sbhe_n = bq.sbhe_n;
    assign o_sbhe_oe = bq.sbhe_oe;
    assign o_memcs16_n = 1'h0;
    assign o_memcs16_oe = bq.memcs_oe;
    assign o_rstdrv = bq.rstdrv;
    assign o_sd = bq.sd;
    assign o_sd_oe = bq.sd_oe;

endmodule

// ### verification/isa_cmd_asserts.sv
// Purpose: Port-level checks for the ISA command block
// Assumes: Request words stay stable while busy
// Notes: Bus-side relations use the bus clock
`timescale 1ns/10ps
module isa_cmd_asserts (
    // Clocks and reset
    input wire logic i_clk,
    input wire logic i_bus_clk,
    input wire logic i_reset_n,
    // Request side
    input wire isa_cmd_pkg::kind_e i_req_kind,
    input wire logic [31:0] i_req_addr,
    input wire logic [1:0] i_req_be,
    input wire logic o_req_busy,
    input wire logic i_soft_bus_reset,
    input wire logic [6:0] i_pci_la_lo,
    input wire logic [6:0] i_pci_la_hi,
    // ISA side
    input wire logic i_master_n,
    input wire logic [6:0] i_la,
    input wire logic o_memr_n,
    input wire logic o_memw_n,
    input wire logic o_cmd_oe,
    input wire logic o_smemr_n,
    input wire logic o_smemw_n,
    input wire logic o_sbhe_n,
    input wire logic o_sbhe_oe,
    input wire logic o_memcs16_n,
    input wire logic o_memcs16_oe,
    input wire logic o_rstdrv,
    input wire logic o_sd_oe
);
    logic in_win;
    assign in_win = (i_la >= i_pci_la_lo) && (i_la <= i_pci_la_hi);

    chk_sbhe_upper: assert property (@(posedge i_bus_clk) disable iff (!i_reset_n)
        o_req_busy && i_req_kind == isa_cmd_pkg::KIND_MASTER && i_req_be[1] && o_sbhe_oe
        |-> !o_sbhe_n) else $error("byte high enable missing");
    chk_sbhe_refresh: assert property (@(posedge i_bus_clk) disable iff (!i_reset_n)
        o_req_busy && i_req_kind == isa_cmd_pkg::KIND_REFRESH |-> o_sbhe_n)
        else $error("byte high enable during refresh");
    chk_memcs_pci: assert property (@(posedge i_bus_clk) disable iff (!i_reset_n)
        (!i_master_n && in_win)[*4] |=> o_memcs16_oe && !o_memcs16_n)
        else $error("memory select not pulled");
    chk_bus_release: assert property (@(posedge i_bus_clk) disable iff (!i_reset_n)
        (!i_master_n)[*4] |=> !o_cmd_oe) else $error("strobes driven under external master");
    chk_compat_high: assert property (@(posedge i_bus_clk) disable iff (!i_reset_n)
        o_req_busy && i_req_kind == isa_cmd_pkg::KIND_COMPAT_DMA && i_req_addr[31:24] != 8'h00
        |-> o_memr_n && o_memw_n) else $error("strobe above 16 MB");
    chk_fast_quiet: assert property (@(posedge i_bus_clk) disable iff (!i_reset_n)
        o_req_busy && i_req_kind == isa_cmd_pkg::KIND_FAST_DMA |-> o_memr_n && o_memw_n)
        else $error("strobe in fast DMA");
    chk_smem_limit: assert property (@(posedge i_bus_clk) disable iff (!i_reset_n)
        o_req_busy && o_cmd_oe && i_req_addr[31:20] != 12'h000 |-> o_smemr_n && o_smemw_n)
        else $error("system strobe above 1 MB");
    chk_smem_delay: assert property (@(posedge i_bus_clk) disable iff (!i_reset_n)
        o_cmd_oe && $fell(o_smemr_n) |-> !$past(o_memr_n)) else $error("system read not delayed");
    chk_reset_drive: assert property (@(posedge i_clk)
        !i_reset_n |-> o_rstdrv && !o_sd_oe && o_smemr_n && o_smemw_n)
        else $error("reset levels wrong");
    chk_soft_reset: assert property (@(posedge i_bus_clk) disable iff (!i_reset_n)
        i_soft_bus_reset[*4] |=> o_rstdrv) else $error("soft bus reset not driven");
endmodule

bind isa_bus_command_interface isa_cmd_asserts i_chk (.*);

// ### verification/isa_slave_model.sv
// Purpose: ISA slave answering the command block
// Assumes: Strobe inputs already gated by the drive enable
// Notes: Released lines idle high, as pulled up on the bus
`timescale 1ns/10ps
module isa_slave_model (
    // Bus clock and observed strobes
    input wire logic i_bus_clk,
    input wire logic i_strobe_n,
    input wire logic i_memx_n,
    input wire logic i_smemx_n,
    // Bench controls
    input wire logic i_clr,
    input wire logic i_zws,
    input wire logic [3:0] i_waits,
    // Responses and observations
    output logic o_iochrdy,
    output logic o_zerows_n,
    output logic [15:0] o_sd,
    output int o_len = 0,
    output logic o_mem_seen = 1'b0,
    output logic o_smem_seen = 1'b0
);
    int run = 0;
    logic [15:0] pat = 16'h0000;
    // Wait requested while the command is low and the wait budget is not spent
    assign o_iochrdy = !(!i_strobe_n && (run < i_waits));
    // Zero-wait follows the decoded command in the same clock, never ahead of it
    assign o_zerows_n = !(i_zws && !i_strobe_n);
    // Outside a command strobe the lane is not held, so show a moving pattern
    assign o_sd = !i_strobe_n ? 16'hA55A : pat;
    always @(posedge i_bus_clk) begin
        pat <= ~pat;
        if (!i_strobe_n) begin
            run <= run + 1;
        end else if (run != 0) begin
            o_len <= run;
            run <= 0;
        end
        o_mem_seen <= !i_clr && (o_mem_seen || !i_memx_n);
        o_smem_seen <= !i_clr && (o_smem_seen || !i_smemx_n);
    end
endmodule

// ### verification/testbench.sv
// Purpose: Self-checking bench for the ISA command block
// Assumes: Bench acts as the external master; the slave model answers
// Notes: Cycle lengths are judged against the plain 16-bit length
`timescale 1ns/10ps
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin bad_count++; \
    $display("[FAIL] %s exp %0h got %0h", nm, e, g); end end
module testbench;
    logic i_clk = 0, i_bus_clk = 0, i_reset_n = 0, i_req_valid = 0, i_req_write = 0;
    logic i_req_mem = 0, i_req_16bit = 0, i_soft_bus_reset = 0, i_master_n = 1;
    logic ext_memr_n = 1, clr = 1, zws = 0;
    isa_cmd_pkg::kind_e i_req_kind = isa_cmd_pkg::KIND_MASTER;
    logic [31:0] i_req_addr = 32'h0;
    logic [1:0] i_req_be = 2'h3;
    logic [15:0] i_req_wdata = 16'h1234;
    logic [6:0] i_pci_la_lo = 7'h10, i_pci_la_hi = 7'h1F, i_la = 7'h00;
    logic [3:0] waits = 4'h0;
    logic o_req_busy, o_done, o_cmd_oe, o_memr_n, o_memw_n, o_ior_n, o_iow_n, o_smemr_n;
    logic o_smemw_n, o_sbhe_n, o_sbhe_oe, o_memcs16_n, o_memcs16_oe, o_rstdrv, o_sd_oe;
    logic i_iochrdy, i_zerows_n, i_memr_n, i_memw_n, mem_seen, smem_seen;
    logic [15:0] o_rdata, o_sd, i_sd, slv_sd;
    int bad_count = 0, n_checks = 0, len, l16, lio;
    assign i_memr_n = o_cmd_oe ? o_memr_n : ext_memr_n;
    assign i_memw_n = o_cmd_oe ? o_memw_n : 1'b1;
    assign i_sd = o_sd_oe ? o_sd : slv_sd;
    isa_bus_command_interface i_dut (.*);
    isa_slave_model i_slave (.i_bus_clk(i_bus_clk),
        .i_strobe_n((o_memr_n & o_memw_n & o_ior_n & o_iow_n) | !o_cmd_oe),
        .i_memx_n((o_memr_n & o_memw_n) | !o_cmd_oe), .i_smemx_n(o_smemr_n & o_smemw_n),
        .i_clr(clr), .i_zws(zws), .i_waits(waits), .o_iochrdy(i_iochrdy),
        .o_zerows_n(i_zerows_n), .o_sd(slv_sd), .o_len(len), .o_mem_seen(mem_seen),
        .o_smem_seen(smem_seen));
    initial forever #25 i_clk = ~i_clk;
    initial begin
        #7;
        forever #15 i_bus_clk = ~i_bus_clk;
    end
    // ------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------
    task automatic cyc(input isa_cmd_pkg::kind_e k, input logic w, m, b,
        input logic [31:0] a, input logic z, input logic [3:0] wt);
        int t;
        @(negedge i_clk);
        clr = 1;
        zws = z;
        waits = wt;
        i_req_kind = k;
        i_req_write = w;
        i_req_mem = m;
        i_req_16bit = b;
        i_req_addr = a;
        repeat (3) @(negedge i_clk);
        clr = 0;
        i_req_valid = 1;
        @(negedge i_clk);
        i_req_valid = 0;
        t = 0;
        while (o_done !== 1'b1 && t < 500) begin
            @(negedge i_clk);
            t++;
        end
        `CHK("done", 1'b1, o_done)
    endtask
    task test_done;
        $display("checks %0d mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    task t_reset;
        repeat (10) @(negedge i_clk);
        `CHK("rstdrv", 1'b1, o_rstdrv)
        `CHK("sd_oe", 1'b0, o_sd_oe)
        `CHK("smemr", 1'b1, o_smemr_n)
        i_reset_n = 1;
        repeat (10) @(negedge i_clk);
        `CHK("rstdrv off", 1'b0, o_rstdrv)
        $display("t_reset done");
    endtask
    task t_len;
        cyc(isa_cmd_pkg::KIND_MASTER, 0, 1, 1, 32'h4000, 0, 0);
        l16 = len;
        `CHK("rdata", 16'hA55A, o_rdata)
        `CHK("smem low 1M", 1'b1, smem_seen)
        cyc(isa_cmd_pkg::KIND_MASTER, 1, 1, 0, 32'h4000, 0, 0);
        `CHK("len8", l16 + 3, len)
        cyc(isa_cmd_pkg::KIND_MASTER, 0, 1, 0, 32'h4000, 1, 0);
        `CHK("zws8", l16, len)
        cyc(isa_cmd_pkg::KIND_MASTER, 0, 1, 1, 32'h4000, 1, 0);
        `CHK("zws16", l16 - 1, len)
        `CHK("rdata zws", 16'hA55A, o_rdata)
        cyc(isa_cmd_pkg::KIND_MASTER, 0, 0, 1, 32'h0300, 0, 0);
        lio = len;
        cyc(isa_cmd_pkg::KIND_MASTER, 0, 0, 1, 32'h0300, 1, 0);
        `CHK("io16 zws", lio, len)
        cyc(isa_cmd_pkg::KIND_MASTER, 0, 1, 1, 32'h4000, 1, 4'h4);
        `CHK("wait wins", 1'b1, len > l16)
        $display("t_len done");
    endtask
    task t_kinds;
        cyc(isa_cmd_pkg::KIND_COMPAT_DMA, 0, 1, 1, 32'h0100_0000, 0, 0);
        `CHK("compat 16M", 1'b0, mem_seen)
        cyc(isa_cmd_pkg::KIND_COMPAT_DMA, 1, 1, 1, 32'h00FF_F000, 0, 0);
        `CHK("compat low", 1'b1, mem_seen)
        `CHK("smem 1M", 1'b0, smem_seen)
        cyc(isa_cmd_pkg::KIND_FAST_DMA, 1, 1, 1, 32'h1000, 0, 0);
        `CHK("fast", 1'b0, mem_seen)
        cyc(isa_cmd_pkg::KIND_MASTER, 1, 1, 1, 32'h0010_0000, 0, 0);
        `CHK("smem edge", 1'b0, smem_seen)
        cyc(isa_cmd_pkg::KIND_MASTER, 1, 1, 1, 32'h000F_FFFE, 0, 0);
        `CHK("smem below", 1'b1, smem_seen)
        cyc(isa_cmd_pkg::KIND_REFRESH, 0, 1, 1, 32'h0, 0, 0);
        `CHK("refresh rd", 1'b1, mem_seen)
        $display("t_kinds done");
    endtask
    task t_ext;
        @(negedge i_clk);
        i_soft_bus_reset = 1;
        i_la = 7'h12;
        i_master_n = 0; // grant assumed seen already
        repeat (24) @(negedge i_clk); // soft reset held over 1 us
        `CHK("soft rst", 1'b1, o_rstdrv)
        `CHK("cmd_oe", 1'b0, o_cmd_oe)
        `CHK("memcs16", 1'b1, o_memcs16_oe)
        i_soft_bus_reset = 0;
        i_la = 7'h05;
        ext_memr_n = 0;
        repeat (8) @(negedge i_clk);
        `CHK("ext smemr", 1'b0, o_smemr_n)
        `CHK("memcs16 off", 1'b0, o_memcs16_oe)
        ext_memr_n = 1;
        i_master_n = 1;
        repeat (10) @(negedge i_clk);
        `CHK("reclaim", 1'b1, o_cmd_oe)
        `CHK("soft off", 1'b0, o_rstdrv)
        $display("t_ext done");
    endtask
    initial begin
        #3_000_000;
        bad_count++;
        test_done;
    end
    initial begin
        t_reset;
        t_len;
        t_kinds;
        t_ext;
        test_done;
    end
endmodule
